/* logic/fapc_regs.sv */
// fifo / secondary poll configuration register bank with trigger timer and fifo write gate
//
// Contract
// - 4-bit poll rate code in bits 3:0; codes 1..11 valid, others reserved.
// - bits 7:4 give readout-to-trigger delay in 2.5 ms steps.
// - offset zero means trigger issued immediately after readout completes.
// - secondary poll configuration resets to 0x46.
// - downsample field bits 6:4; factor is two to the field value.
// - bit 7 selects filtered (1) or unfiltered (0) samples for the fifo.
// - downsample register resets to 0x80; bits 3:0 reserved, not writable.
// - 13-bit watermark: low byte at 0x46, bits 12:8 at 0x47 bits 4:0.
// - watermark registers reset to 0x00 and 0x02, level 512 bytes.
// - bit 0 of behaviour config set stops writing into a full fifo.
// - bit 1 of behaviour config enables timestamp frame after last data frame.
// - behaviour config resets to 0x02; bits 7:2 reserved, not writable.
// - fifo byte fill level readable over two read-only registers, 13..8 upper.
`timescale 1ns/10ps
module fapc_regs #(
  parameter int unsigned STEP_CYCLES = fapc_pkg::OFFSET_STEP_CYCLES,
  parameter int          FILL_W      = 14
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [7:0]            reg_rdata_out,
  input  wire logic [FILL_W-1:0]     fill_level_in,
  input  wire logic                  fifo_full_in,
  input  wire logic                  sample_valid_in,
  input  wire logic                  readout_done_in,
  output fapc_pkg::fapc_cfg_type     cfg_out,
  output logic                       rate_valid_out,
  output logic                       trigger_out,
  output logic                       fifo_write_out,
  output logic                       watermark_out,
  output logic                       irq_out
);
  typedef enum logic [0:0] {
    FAPC_IDLE = 1'b0,
    FAPC_WAIT = 1'b1
  } fapc_state_type;

  // ****************************************
  // register file
  // ****************************************
  logic [7:0]  poll_reg, poll_next;
  logic [7:0]  downs_reg, downs_next;
  logic [7:0]  wtm_lo_reg, wtm_lo_next;
  logic [7:0]  wtm_hi_reg, wtm_hi_next;
  logic [7:0]  behav_reg, behav_next;
  logic [1:0]  status_reg, status_next;
  logic [1:0]  mask_reg, mask_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [1:0]  irq_set;
  logic [12:0] wtm_level;

  assign wtm_level = {wtm_hi_reg[4:0], wtm_lo_reg};

  // writes: only writable bits land, reserved bits stay zero
  always_comb begin
    poll_next   = poll_reg;
    downs_next  = downs_reg;
    wtm_lo_next = wtm_lo_reg;
    wtm_hi_next = wtm_hi_reg;
    behav_next  = behav_reg;
    mask_next   = mask_reg;
    if (reg_wr_in) begin
      case (reg_addr_in)
        fapc_pkg::ADDR_POLL_CFG:   poll_next   = reg_wdata_in;
        fapc_pkg::ADDR_DOWNS_CFG:  downs_next  = reg_wdata_in & fapc_pkg::MASK_DOWNS_CFG;
        fapc_pkg::ADDR_WTM_LOW:    wtm_lo_next = reg_wdata_in;
        fapc_pkg::ADDR_WTM_HIGH:   wtm_hi_next = reg_wdata_in & fapc_pkg::MASK_WTM_HIGH;
        fapc_pkg::ADDR_BEHAV_CFG:  behav_next  = reg_wdata_in & fapc_pkg::MASK_BEHAV_CFG;
        fapc_pkg::ADDR_IRQ_MASK:   mask_next   = reg_wdata_in[1:0];
        default: begin
        end
      endcase
    end
  end

  // sticky status: a set in the clearing cycle wins
  always_comb begin
    status_next = status_reg;
    if (reg_wr_in && reg_addr_in == fapc_pkg::ADDR_IRQ_STATUS) begin
      status_next = status_reg & ~reg_wdata_in[1:0];
    end
    status_next = status_next | irq_set;
  end

  // read mux, answer one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        fapc_pkg::ADDR_FILL_LOW:   rdata_next = fill_level_in[7:0];
        fapc_pkg::ADDR_FILL_HIGH:  rdata_next = 8'(fill_level_in[FILL_W-1:8])
                                                & fapc_pkg::MASK_FILL_HIGH;
        fapc_pkg::ADDR_POLL_CFG:   rdata_next = poll_reg;
        fapc_pkg::ADDR_DOWNS_CFG:  rdata_next = downs_reg;
        fapc_pkg::ADDR_WTM_LOW:    rdata_next = wtm_lo_reg;
        fapc_pkg::ADDR_WTM_HIGH:   rdata_next = wtm_hi_reg;
        fapc_pkg::ADDR_BEHAV_CFG:  rdata_next = behav_reg;
        fapc_pkg::ADDR_IRQ_STATUS: rdata_next = {6'h00, status_reg};
        fapc_pkg::ADDR_IRQ_MASK:   rdata_next = {6'h00, mask_reg};
        default:                   rdata_next = 8'h00;
      endcase
    end
  end

  // register update
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      poll_reg   <= fapc_pkg::RST_POLL_CFG;
      downs_reg  <= fapc_pkg::RST_DOWNS_CFG;
      wtm_lo_reg <= fapc_pkg::RST_WTM_LOW;
      wtm_hi_reg <= fapc_pkg::RST_WTM_HIGH;
      behav_reg  <= fapc_pkg::RST_BEHAV_CFG;
      status_reg <= fapc_pkg::RST_IRQ;
      mask_reg   <= fapc_pkg::RST_IRQ;
      rdata_reg  <= 8'h00;
    end else begin
      poll_reg   <= poll_next;
      downs_reg  <= downs_next;
      wtm_lo_reg <= wtm_lo_next;
      wtm_hi_reg <= wtm_hi_next;
      behav_reg  <= behav_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign irq_out       = |(status_reg & mask_reg);

  // configuration view, straight from the flops
  always_comb begin
    cfg_out.poll_rate     = poll_reg[fapc_pkg::RATE_LSB +: 4];
    cfg_out.trig_offset   = poll_reg[fapc_pkg::OFFSET_LSB +: 4];
    cfg_out.downs_exp     = downs_reg[fapc_pkg::DOWNS_LSB +: 3];
    cfg_out.filt_sel      = downs_reg[fapc_pkg::FILT_BIT];
    cfg_out.watermark     = wtm_level;
    cfg_out.stop_on_full  = behav_reg[fapc_pkg::STOP_FULL_BIT];
    cfg_out.time_frame_en = behav_reg[fapc_pkg::TIME_EN_BIT];
  end

  // ****************************************
  // watermark flag and rate check
  // ****************************************
  logic wtm_reg, wtm_next;
  logic rate_ok_reg, rate_ok_next;

  // level compare; rising edge feeds the sticky status
  always_comb begin
    wtm_next     = ({{(32-FILL_W){1'b0}}, fill_level_in} >= {19'h0, wtm_level});
    rate_ok_next = (poll_reg[3:0] >= fapc_pkg::RATE_CODE_LOWEST) &&
                   (poll_reg[3:0] <= fapc_pkg::RATE_CODE_HIGHEST);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wtm_reg     <= 1'b0;
      rate_ok_reg <= 1'b0;
    end else begin
      wtm_reg     <= wtm_next;
      rate_ok_reg <= rate_ok_next;
    end
  end

  assign watermark_out  = wtm_reg;
  assign rate_valid_out = rate_ok_reg;

  // ****************************************
  // fifo write gate: downsample and stop-on-full
  // ****************************************
  logic [6:0] skip_reg, skip_next;
  logic       wr_reg, wr_next;
  logic       drop;

  // one sample of every 2**n passes; a full fifo blocks it only in stop mode
  always_comb begin
    skip_next = skip_reg;
    wr_next   = 1'b0;
    drop      = 1'b0;
    if (sample_valid_in) begin
      if (skip_reg == 7'h00) begin
        skip_next = 7'((8'h01 << downs_reg[fapc_pkg::DOWNS_LSB +: 3]) - 8'h01);
        if (behav_reg[fapc_pkg::STOP_FULL_BIT] && fifo_full_in) begin
          drop = 1'b1;
        end else begin
          wr_next = 1'b1;
        end
      end else begin
        skip_next = skip_reg - 7'h01;
      end
    end
  end

  assign irq_set = {drop, wtm_next & ~wtm_reg};

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      skip_reg <= 7'h00;
      wr_reg   <= 1'b0;
    end else begin
      skip_reg <= skip_next;
      wr_reg   <= wr_next;
    end
  end

  assign fifo_write_out = wr_reg;

  // ****************************************
  // readout to trigger timer
  // ****************************************
  fapc_state_type state_reg, state_next;
  logic [31:0]    cyc_reg, cyc_next;
  logic [3:0]     steps_reg, steps_next;
  logic           trig_reg, trig_next;

  // offset zero fires at once; otherwise count offset steps of STEP_CYCLES
  always_comb begin
    state_next = state_reg;
    cyc_next   = cyc_reg;
    steps_next = steps_reg;
    trig_next  = 1'b0;
    case (state_reg)
      FAPC_IDLE: begin
        if (readout_done_in) begin
          if (poll_reg[fapc_pkg::OFFSET_LSB +: 4] == 4'h0) begin
            trig_next = 1'b1;
          end else begin
            steps_next = poll_reg[fapc_pkg::OFFSET_LSB +: 4];
            cyc_next   = 32'(STEP_CYCLES - 1);
            state_next = FAPC_WAIT;
          end
        end
      end
      FAPC_WAIT: begin
        if (cyc_reg != 32'h0) begin
          cyc_next = cyc_reg - 32'h1;
        end else if (steps_reg == 4'h1) begin
          trig_next  = 1'b1;
          state_next = FAPC_IDLE;
        end else begin
          steps_next = steps_reg - 4'h1;
          cyc_next   = 32'(STEP_CYCLES - 1);
        end
      end
      default: state_next = FAPC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= FAPC_IDLE;
      cyc_reg   <= 32'h0;
      steps_reg <= 4'h0;
      trig_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cyc_reg   <= cyc_next;
      steps_reg <= steps_next;
      trig_reg  <= trig_next;
    end
  end

  assign trigger_out = trig_reg;

  // ****************************************
  // checks
  // ****************************************
  // watched interval of the timer, for the delay check
  logic [35:0] wait_cnt_reg;
  logic [3:0]  wait_off_reg;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || (state_reg == FAPC_IDLE && readout_done_in)) begin
      wait_cnt_reg <= 36'h0;
      wait_off_reg <= rst_in ? 4'h0 : poll_reg[7:4];
    end else begin
      wait_cnt_reg <= wait_cnt_reg + 36'h1;
    end
  end

  rate_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !$past(rst_in) |-> rate_valid_out == ($past(poll_reg[3:0]) inside {[4'h1:4'hB]}))
    else $error("poll rate validity wrong");
  trig_delay_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(trigger_out) && wait_off_reg != 4'h0 |->
      wait_cnt_reg == 36'(wait_off_reg) * 36'(STEP_CYCLES))
    else $error("trigger delay wrong");
  trig_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == FAPC_IDLE && readout_done_in && poll_reg[7:4] == 4'h0 |=> trigger_out)
    else $error("zero offset trigger late");
  reset_vals_a: assert property (@(posedge clk_sys_in)
    $past(rst_in) |-> poll_reg == 8'h46 && downs_reg == 8'h80 && behav_reg == 8'h02
      && wtm_level == 13'h0200)
    else $error("reset values wrong");
  downs_gap_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sample_valid_in && skip_reg == 7'h00 && downs_reg[6:4] == 3'h1 && !fifo_full_in
      ##1 sample_valid_in |-> ##1 !fifo_write_out)
    else $error("downsample passed extra sample");
  filt_view_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(reg_wr_in && reg_addr_in == 8'h45) |-> cfg_out.filt_sel == $past(reg_wdata_in[7]))
    else $error("filter select not taken");
  reserved_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    downs_reg[3:0] == 4'h0 && wtm_hi_reg[7:5] == 3'h0 && behav_reg[7:2] == 6'h00)
    else $error("reserved bit set");
  wtm_read_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == 8'h47 |=> reg_rdata_out == {3'h0, wtm_level[12:8]})
    else $error("watermark high read wrong");
  stop_full_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    behav_reg[0] && fifo_full_in |=> !fifo_write_out)
    else $error("write into full fifo");
  time_en_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(reg_wr_in && reg_addr_in == 8'h48) |-> cfg_out.time_frame_en == $past(reg_wdata_in[1]))
    else $error("timestamp enable not taken");
  fill_read_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == 8'h24 |=> reg_rdata_out == $past(fill_level_in[7:0]))
    else $error("fill level read wrong");
  wtm_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !$past(rst_in) |-> watermark_out == ($past(fill_level_in) >= $past(wtm_level)))
    else $error("watermark flag wrong");

  trig_delay_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == FAPC_WAIT ##1 trigger_out);
  drop_full_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) drop);
  wtm_irq_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(watermark_out) ##1 irq_out);
endmodule

/* inc/fapc_pkg.sv */
// shared constants and carrier types of the fifo / secondary poll configuration bank
package fapc_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_FILL_LOW   = 8'h24;
  localparam logic [7:0] ADDR_FILL_HIGH  = 8'h25;
  localparam logic [7:0] ADDR_POLL_CFG   = 8'h44;
  localparam logic [7:0] ADDR_DOWNS_CFG  = 8'h45;
  localparam logic [7:0] ADDR_WTM_LOW    = 8'h46;
  localparam logic [7:0] ADDR_WTM_HIGH   = 8'h47;
  localparam logic [7:0] ADDR_BEHAV_CFG  = 8'h48;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h60;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h61;

  // ****************************************
  // reset values, writable masks and the fill high readback mask
  // ****************************************
  localparam logic [7:0] RST_POLL_CFG   = 8'h46;
  localparam logic [7:0] RST_DOWNS_CFG  = 8'h80;
  localparam logic [7:0] RST_WTM_LOW    = 8'h00;
  localparam logic [7:0] RST_WTM_HIGH   = 8'h02;
  localparam logic [7:0] RST_BEHAV_CFG  = 8'h02;
  localparam logic [1:0] RST_IRQ        = 2'h0;
  localparam logic [7:0] MASK_DOWNS_CFG = 8'hF0;
  localparam logic [7:0] MASK_WTM_HIGH  = 8'h1F;
  localparam logic [7:0] MASK_BEHAV_CFG = 8'h03;
  localparam logic [7:0] MASK_FILL_HIGH = 8'h3F;

  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int RATE_LSB        = 0;
  localparam int OFFSET_LSB      = 4;
  localparam int DOWNS_LSB       = 4;
  localparam int FILT_BIT        = 7;
  localparam int STOP_FULL_BIT   = 0;
  localparam int TIME_EN_BIT     = 1;
  localparam int IRQ_WTM_BIT     = 0;
  localparam int IRQ_DROP_BIT    = 1;
  localparam logic [3:0] RATE_CODE_LOWEST  = 4'h1;
  localparam logic [3:0] RATE_CODE_HIGHEST = 4'hB;

  // ****************************************
  // timing
  // ****************************************
  localparam real OFFSET_STEP_MS = 2.5;
  localparam real CLK_PERIOD_NS  = 10.0;
  localparam int  OFFSET_STEP_CYCLES = int'(OFFSET_STEP_MS * 1.0e6 / CLK_PERIOD_NS);

  // configuration seen by the surrounding logic
  typedef struct packed {
    logic [3:0]  poll_rate;
    logic [3:0]  trig_offset;
    logic [2:0]  downs_exp;
    logic        filt_sel;
    logic [12:0] watermark;
    logic        stop_on_full;
    logic        time_frame_en;
  } fapc_cfg_type;
endpackage

/* verification/tb_fapc_regs.sv */
// self-checking bench of the fifo / secondary poll configuration register bank
`timescale 1ns/10ps
module tb_fapc_regs;
  // ****************************************
  // signals and counters
  // ****************************************
  localparam int STEP = 4;
  localparam logic [7:0] RA [7] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h60, 8'h61};
  localparam logic [7:0] RV [7] = '{8'h46, 8'h80, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00};
  localparam logic [7:0] RM [7] = '{8'hFF, 8'hF0, 8'hFF, 8'h1F, 8'h03, 8'h00, 8'h03};
  logic                   clk_sys_in   = 1'b0;
  logic                   rst_in       = 1'b1;
  logic [7:0]             reg_addr     = 8'h00;
  logic [7:0]             reg_wdata    = 8'h00;
  logic                   reg_wr       = 1'b0;
  logic                   reg_rd       = 1'b0;
  logic [7:0]             reg_rdata;
  logic [13:0]            fill_level   = 14'h0000;
  logic                   fifo_full    = 1'b0;
  logic                   sample_valid = 1'b0;
  logic                   readout_done = 1'b0;
  fapc_pkg::fapc_cfg_type cfg;
  logic                   rate_valid;
  logic                   trigger;
  logic                   fifo_write;
  logic                   watermark;
  logic                   irq;
  int                     fails        = 0;
  int                     total_checks = 0;
  int                     cycles       = 0;

  // 100 MHz system clock
  always #5 clk_sys_in = ~clk_sys_in;

  // short offset step keeps trigger waits to a few cycles
  fapc_regs #(.STEP_CYCLES(STEP), .FILL_W(14)) i_dut (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .reg_addr_in     (reg_addr),
    .reg_wdata_in    (reg_wdata),
    .reg_wr_in       (reg_wr),
    .reg_rd_in       (reg_rd),
    .reg_rdata_out   (reg_rdata),
    .fill_level_in   (fill_level),
    .fifo_full_in    (fifo_full),
    .sample_valid_in (sample_valid),
    .readout_done_in (readout_done),
    .cfg_out         (cfg),
    .rate_valid_out  (rate_valid),
    .trigger_out     (trigger),
    .fifo_write_out  (fifo_write),
    .watermark_out   (watermark),
    .irq_out         (irq)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr    <= 1'b0;
    // step off the edge so callers see the written register settled
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp, "read data");
  endtask

  task automatic do_reset();
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
  endtask

  // back-to-back samples; exp bit i is the expected write for sample i
  task automatic burst(input int n, input logic [7:0] exp);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_in);
      sample_valid <= 1'b1;
      #1;
      if (i > 0) chk(fifo_write, exp[i-1], "fifo write");
    end
    @(posedge clk_sys_in);
    sample_valid <= 1'b0;
    #1;
    chk(fifo_write, exp[n-1], "fifo write");
  endtask

  // cycles from the readout pulse to the trigger, then trigger must drop
  task automatic trig_check(input int exp_k);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    readout_done <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      readout_done <= 1'b0;
      #1;
      k++;
    end while (trigger !== 1'b1 && k < 200);
    chk(k, exp_k, "trigger delay");
    @(posedge clk_sys_in);
    #1;
    chk(trigger, 1'b0, "trigger width");
  endtask

  task automatic reset_table();
    for (int i = 0; i < 7; i++) reg_check(RA[i], RV[i]);
    chk(cfg, {4'h6, 4'h4, 3'h0, 1'b1, 13'h0200, 1'b0, 1'b1}, "reset cfg");
    chk(rate_valid, 1'b1, "reset rate valid");
  endtask

  // ****************************************
  // hang guard and main sequence
  // ****************************************
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  initial begin
    do_reset();
    reset_table();
    // reserved bits are dropped, unmapped and read-only places ignore writes
    for (int i = 0; i < 7; i++) if (i != 5) reg_write(RA[i], 8'hFF);
    for (int i = 0; i < 7; i++) if (i != 5) reg_check(RA[i], RM[i]);
    chk(cfg, {4'hF, 4'hF, 3'h7, 1'b1, 13'h1FFF, 1'b1, 1'b1}, "full cfg");
    for (int i = 0; i < 7; i++) if (i != 5) reg_write(RA[i], 8'h00);
    for (int i = 0; i < 7; i++) if (i != 5) reg_check(RA[i], 8'h00);
    reg_write(8'h30, 8'hA5);
    reg_write(8'h24, 8'hFF);
    reg_check(8'h30, 8'h00);
    reg_check(8'h24, 8'h00);
    // every poll rate code, reserved ones are flagged
    for (int c = 0; c < 16; c++) begin
      reg_write(8'h44, {4'h4, 4'(c)});
      @(posedge clk_sys_in);
      #1;
      chk(rate_valid, (c >= 1 && c <= 11), "rate valid");
      reg_check(8'h44, {4'h4, 4'(c)});
    end
    // offset zero triggers at once, offset three waits three steps
    reg_write(8'h44, 8'h06);
    trig_check(1);
    reg_write(8'h44, 8'h36);
    chk(cfg.trig_offset, 4'h3, "offset field");
    trig_check(3 * STEP + 1);
    // watermark across both halves, just below then at the level
    reg_write(8'h46, 8'h10);
    reg_write(8'h47, 8'h01);
    chk(cfg.watermark, 13'h0110, "watermark");
    reg_write(8'h60, 8'h03);
    reg_check(8'h60, 8'h00);
    fill_level <= 14'h010F;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk(watermark, 1'b0, "below watermark");
    fill_level <= 14'h0110;
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk(watermark, 1'b1, "at watermark");
    chk(irq, 1'b0, "masked irq");
    reg_check(8'h60, 8'h01);
    reg_write(8'h61, 8'h01);
    #1;
    chk(irq, 1'b1, "unmasked irq");
    reg_write(8'h60, 8'h01);
    reg_check(8'h60, 8'h00);
    chk(irq, 1'b0, "cleared irq");
    // fill level readback through both halves
    fill_level <= 14'h2A5C;
    reg_check(8'h24, 8'h5C);
    reg_check(8'h25, 8'h2A);
    fill_level <= 14'h0000;
    // downsample by two, unfiltered source
    reg_write(8'h45, 8'h10);
    chk({cfg.downs_exp, cfg.filt_sel}, {3'h1, 1'b0}, "downsample cfg");
    burst(4, 8'b0101);
    // stop on full drops the sample and flags it; timestamp frame off
    reg_write(8'h45, 8'h80);
    reg_write(8'h48, 8'h01);
    chk({cfg.stop_on_full, cfg.time_frame_en}, 2'b10, "behaviour cfg");
    reg_write(8'h61, 8'h02);
    fifo_full <= 1'b1;
    burst(1, 8'b0);
    reg_check(8'h60, 8'h02);
    chk(irq, 1'b1, "drop irq");
    reg_write(8'h48, 8'h00);
    burst(2, 8'b11);
    fifo_full <= 1'b0;
    // second reset in mid-run restores every register
    do_reset();
    reset_table();
    end_of_test();
  end
endmodule
